// ---- design/pmbus_target_consts.vh ----
`ifndef PMBUS_TARGET_CONSTS_VH
`define PMBUS_TARGET_CONSTS_VH

// Controller clock rate and lock-up limit
`define CLOCK_KHZ 125000
`define LOCKUP_MS 35
`define LOCK_WIDTH 23

// Addressing
`define TARGET_PREFIX 4'hB
`define BROADCAST_ADDR 7'h00

// Check byte
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// Command codes with side effects in this block
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STATUS_WORD 8'h79

// Word formats
`define VOUT_EXPONENT 5'h09
`define EXP_MSB 15
`define EXP_LSB 11
`define MANT_MSB 10

// Filler sent after the check byte
`define PAD_BYTE 8'hFF

// Serial state, one-hot
`define ST_IDLE 6'h01
`define ST_ADDR 6'h02
`define ST_ACK 6'h04
`define ST_RX 6'h08
`define ST_TX 6'h10
`define ST_HACK 6'h20

`define BIT_LAST 4'h8
`define COUNT_MAX 6'h3F

`endif

// ---- design/psu_pmbus_target_interface.v ----
// Function
// - Bus low over 35 ms aborts, releases lines
// - Works at 100 and 400 kHz, default 100
// - Commands run with or without check byte
// - Check byte is CRC-8, x8+x2+x+1
// - CRC spans all bytes, incl. read setup
// - Last data sender appends check byte
// - Alert high normally, latched low on change
// - Alert reasserts if alarm persists after clear
// - Alert on listed faults and bus errors
// - Alert clears on clear, recycle, status read
// - Standard write framing, low byte first
// - Standard read returns low byte first
// - Over two bytes use block write format
// - Block read: count, up to 48, check
// - Linear word: 5-bit exponent, 11-bit mantissa
// - Output voltage: 16-bit mantissa, exponent 9
// - Stretch only after ninth bit, 25 ms max; this block never stretches the clock
// - Answer 1011 plus pins, and broadcast 0x00
`include "pmbus_target_consts.vh"

module psu_pmbus_target_interface
#(
   parameter [`LOCK_WIDTH-1:0] LOCKUP_CYCLES = `LOCKUP_MS * `CLOCK_KHZ,
   parameter FLAG_WIDTH = 6
)
(
   input wire clock,
   input wire rst_n,
   input wire sclIn,
   output wire sclOut,
   output wire sclOe,
   input wire sdaIn,
   output wire sdaOut,
   output reg sdaOe,
   input wire [2:0] addressSelectPins,
   output wire alertOut,
   output reg alertOe,
   input wire enablePinN,
   input wire [FLAG_WIDTH-1:0] statusFlags,
   input wire invalidCommand,
   input wire outputOnCmd,
   input wire [5:0] writeLength,
   input wire [5:0] readLength,
   input wire [7:0] txData,
   input wire voutFormat,
   output reg [7:0] cmdCode,
   output reg cmdValid,
   output reg [7:0] rxData,
   output reg rxValid,
   output reg [15:0] writeWord,
   output reg writeExec,
   output reg pecPresent,
   output reg pecError,
   output reg readReq,
   output reg [5:0] readIndex,
   output reg [4:0] wordExponent,
   output reg [15:0] wordMantissa,
   output reg busAbort
);

   function [7:0] crc8;
      input [7:0] c;
      input [7:0] d;
      integer i;
      reg [7:0] r;
      begin
         r = c ^ d;
         for (i = 0; i < 8; i = i + 1)
         begin
            r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
         end
         crc8 = r;
      end
   endfunction

   reg [1:0] sclSync;
   reg [1:0] sdaSync;
   reg [1:0] enSync;
   reg [2:0] addrMeta;
   reg [2:0] addrSel;
   reg sclPrev;
   reg sdaPrev;
   reg [5:0] state;
   reg [3:0] bitCnt;
   reg [7:0] shift;
   reg readMode;
   reg gotCmd;
   reg inFrame;
   reg hostAck;
   reg [5:0] byteNum;
   reg [7:0] crc;
   reg [`LOCK_WIDTH-1:0] lockCnt;
   reg clearFaults;
   reg statusRead;
   reg [FLAG_WIDTH-1:0] flagsPrev;
   reg enablePrev;
   reg opPrev;
   reg recheck;

   wire scl = sclSync[1];
   wire sda = sdaSync[1];
   wire sclRise = scl & ~sclPrev;
   wire sclFall = ~scl & sclPrev;
   wire startSeen = scl & sclPrev & sdaPrev & ~sda;
   wire stopSeen = scl & sclPrev & ~sdaPrev & sda;
   wire lockHit = (lockCnt == LOCKUP_CYCLES - 1'b1);
   wire addrMatch = (shift[7:1] == {`TARGET_PREFIX, addrSel}) ||
      ((shift[7:1] == `BROADCAST_ADDR) && !shift[0]);
   // Check byte follows the last data byte; padding after that
   wire [7:0] txSel = (readIndex == readLength) ? crc :
      ((readIndex > readLength) ? `PAD_BYTE : txData);
   wire enableOn = ~enSync[1];
   wire anyEvent = (|(statusFlags ^ flagsPrev)) | pecError | invalidCommand | busAbort;
   wire anyClear = clearFaults | statusRead | (enableOn & ~enablePrev) | (outputOnCmd & ~opPrev);

   // Open drain: only the enables move; the clock is never stretched
   assign sclOut = 1'b0;
   assign sclOe = 1'b0;
   assign sdaOut = 1'b0;
   assign alertOut = 1'b0;

   // Oversampling at the controller rate covers both bus speeds
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         enSync <= 2'h3;
         addrMeta <= 3'h7;
         addrSel <= 3'h7;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         enSync <= {enSync[0], enablePinN};
         addrMeta <= addressSelectPins;
         addrSel <= addrMeta;
         sclPrev <= scl;
         sdaPrev <= sda;
      end
   end

   // Traffic and stretching both see the lines high now and then
   always @(posedge clock)
   begin
      if (!rst_n)
         lockCnt <= {`LOCK_WIDTH{1'b0}};
      else if (scl & sda)
         lockCnt <= {`LOCK_WIDTH{1'b0}};
      else if (lockCnt != LOCKUP_CYCLES)
         lockCnt <= lockCnt + 1'b1;
   end

   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         state <= `ST_IDLE;
         bitCnt <= 4'h0;
         shift <= 8'h00;
         readMode <= 1'b0;
         gotCmd <= 1'b0;
         inFrame <= 1'b0;
         hostAck <= 1'b0;
         byteNum <= 6'h00;
         crc <= `CRC_INIT;
         sdaOe <= 1'b0;
         cmdCode <= 8'h00;
         cmdValid <= 1'b0;
         rxData <= 8'h00;
         rxValid <= 1'b0;
         writeWord <= 16'h0000;
         writeExec <= 1'b0;
         pecPresent <= 1'b0;
         pecError <= 1'b0;
         readReq <= 1'b0;
         readIndex <= 6'h00;
         busAbort <= 1'b0;
         clearFaults <= 1'b0;
         statusRead <= 1'b0;
      end
      else
      begin
         cmdValid <= 1'b0;
         rxValid <= 1'b0;
         writeExec <= 1'b0;
         pecError <= 1'b0;
         readReq <= 1'b0;
         busAbort <= 1'b0;
         clearFaults <= 1'b0;
         statusRead <= 1'b0;
         if (lockHit)
         begin
            state <= `ST_IDLE;
            sdaOe <= 1'b0;
            inFrame <= 1'b0;
            gotCmd <= 1'b0;
            readMode <= 1'b0;
            busAbort <= 1'b1;
         end
         else if (startSeen)
         begin
            state <= `ST_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
            inFrame <= 1'b1;
            // Repeated start keeps the sum running
            if (!inFrame)
               crc <= `CRC_INIT;
         end
         else if (stopSeen)
         begin
            if (inFrame && gotCmd && !readMode)
            begin
               pecPresent <= (byteNum > writeLength);
               if ((byteNum > writeLength) && (crc != 8'h00))
                  pecError <= 1'b1;
               else
               begin
                  writeExec <= 1'b1;
                  clearFaults <= (cmdCode == `CMD_CLEAR_FAULTS);
               end
            end
            if (inFrame && gotCmd && readMode && (readIndex != 6'h00))
               statusRead <= (cmdCode == `CMD_STATUS_WORD);
            state <= `ST_IDLE;
            sdaOe <= 1'b0;
            inFrame <= 1'b0;
            gotCmd <= 1'b0;
            readMode <= 1'b0;
         end
         else
         begin
            case (state)
               `ST_ADDR, `ST_RX:
               begin
                  if (sclRise)
                  begin
                     shift <= {shift[6:0], sda};
                     bitCnt <= bitCnt + 4'h1;
                  end
                  else if (sclFall && (bitCnt == `BIT_LAST))
                  begin
                     if (state == `ST_ADDR)
                     begin
                        if (addrMatch)
                        begin
                           state <= `ST_ACK;
                           sdaOe <= 1'b1;
                           crc <= crc8(crc, shift);
                           readMode <= shift[0];
                           readIndex <= 6'h00;
                           readReq <= shift[0];
                        end
                        else
                           state <= `ST_IDLE;
                     end
                     else
                     begin
                        state <= `ST_ACK;
                        sdaOe <= 1'b1;
                        crc <= crc8(crc, shift);
                        if (!gotCmd)
                        begin
                           cmdCode <= shift;
                           cmdValid <= 1'b1;
                           gotCmd <= 1'b1;
                           byteNum <= 6'h00;
                        end
                        else
                        begin
                           rxData <= shift;
                           rxValid <= 1'b1;
                           if (byteNum != `COUNT_MAX)
                              byteNum <= byteNum + 6'h01;
                           if (byteNum == 6'h00)
                              writeWord[7:0] <= shift;
                           if (byteNum == 6'h01)
                              writeWord[15:8] <= shift;
                        end
                     end
                  end
               end
               `ST_ACK, `ST_HACK:
               begin
                  if (sclRise)
                     hostAck <= ~sda;
                  else if (sclFall)
                  begin
                     bitCnt <= 4'h0;
                     if (readMode && ((state == `ST_ACK) || hostAck))
                     begin
                        state <= `ST_TX;
                        shift <= txSel;
                        sdaOe <= ~txSel[7];
                        crc <= crc8(crc, txSel);
                        if (readIndex != `COUNT_MAX)
                           readIndex <= readIndex + 6'h01;
                        readReq <= 1'b1;
                     end
                     else if (readMode)
                     begin
                        state <= `ST_IDLE;
                        sdaOe <= 1'b0;
                     end
                     else
                     begin
                        state <= `ST_RX;
                        sdaOe <= 1'b0;
                     end
                  end
               end
               `ST_TX:
               begin
                  if (sclRise)
                     bitCnt <= bitCnt + 4'h1;
                  else if (sclFall)
                  begin
                     if (bitCnt == `BIT_LAST)
                     begin
                        state <= `ST_HACK;
                        sdaOe <= 1'b0;
                     end
                     else
                     begin
                        shift <= {shift[6:0], 1'b0};
                        sdaOe <= ~shift[6];
                     end
                  end
               end
               default:
               begin
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Word view for the command executor
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         wordExponent <= 5'h00;
         wordMantissa <= 16'h0000;
      end
      else if (voutFormat)
      begin
         wordExponent <= `VOUT_EXPONENT;
         wordMantissa <= writeWord;
      end
      else
      begin
         wordExponent <= writeWord[`EXP_MSB:`EXP_LSB];
         wordMantissa <= {{5{writeWord[`MANT_MSB]}}, writeWord[`MANT_MSB:0]};
      end
   end

   // New events beat a clear in the same cycle
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         alertOe <= 1'b0;
         flagsPrev <= {FLAG_WIDTH{1'b0}};
         enablePrev <= 1'b0;
         opPrev <= 1'b0;
         recheck <= 1'b0;
      end
      else
      begin
         flagsPrev <= statusFlags;
         enablePrev <= enableOn;
         opPrev <= outputOnCmd;
         recheck <= anyClear;
         if (anyEvent || (recheck && (|statusFlags)))
            alertOe <= 1'b1;
         else if (anyClear)
            alertOe <= 1'b0;
      end
   end

endmodule // psu_pmbus_target_interface

// ---- sim/pmbus_target_asserts.sv ----
module pmbus_target_checker
#(
   parameter int LOCKUP_CYCLES = 2000,
   parameter int FLAG_WIDTH = 6
)
(
   input wire clock,
   input wire rst_n,
   input wire sclIn,
   input wire sdaIn,
   input wire sdaOe,
   input wire alertOe,
   input wire [FLAG_WIDTH-1:0] statusFlags,
   input wire invalidCommand,
   input wire outputOnCmd,
   input wire voutFormat,
   input wire cmdValid,
   input wire [15:0] writeWord,
   input wire writeExec,
   input wire pecError,
   input wire [4:0] wordExponent,
   input wire [15:0] wordMantissa,
   input wire busAbort
);
   timeunit 1ns;
   timeprecision 1ps;
   int lowCount;
   // Raw pins lead the synchronised copy, so the window is a few cycles wide
   always @(posedge clock)
   begin
      if (!rst_n || (sclIn && sdaIn))
         lowCount <= 0;
      else
         lowCount <= lowCount + 1;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_lockup;
      busAbort |-> lowCount > LOCKUP_CYCLES - 8 && lowCount < LOCKUP_CYCLES + 8 ##1 !sdaOe [*4];
   endproperty
   a_lockup: assert property (p_lockup) else $error("abort timing");
   property p_set;
      invalidCommand || pecError || busAbort || !$stable(statusFlags) |=> alertOe;
   endproperty
   a_set: assert property (p_set) else $error("alert not set");
   property p_cause;
      $rose(alertOe) |-> $past(invalidCommand) || $past(pecError) || $past(busAbort) || $past(statusFlags) != 0;
   endproperty
   a_cause: assert property (p_cause) else $error("alert without cause");
   property p_clear;
      $rose(outputOnCmd) && statusFlags == 0 && $stable(statusFlags) && !invalidCommand |-> ##[1:3] !alertOe;
   endproperty
   a_clear: assert property (p_clear) else $error("alert not cleared");
   property p_persist;
      $fell(alertOe) && statusFlags != 0 |=> alertOe;
   endproperty
   a_persist: assert property (p_persist) else $error("alert not reasserted");
   property p_excl;
      pecError |-> !writeExec;
   endproperty
   a_excl: assert property (p_excl) else $error("bad check byte executed");
   property p_cmdAck;
      cmdValid |-> ##[0:2] sdaOe;
   endproperty
   a_cmdAck: assert property (p_cmdAck) else $error("command not acked");
   property p_vout;
      $past(voutFormat) |-> wordExponent == 5'h09 && wordMantissa == $past(writeWord);
   endproperty
   a_vout: assert property (p_vout) else $error("vout word decode");
   property p_linear;
      !$past(voutFormat) |-> wordExponent == $past(writeWord) >> 11;
   endproperty
   a_linear: assert property (p_linear) else $error("linear exponent");
   c_exec: cover property (writeExec);
   c_pec: cover property (pecError);
   c_abort: cover property (busAbort);
endmodule // pmbus_target_checker

bind psu_pmbus_target_interface pmbus_target_checker #(.LOCKUP_CYCLES(LOCKUP_CYCLES), .FLAG_WIDTH(FLAG_WIDTH))
   pmbus_target_checker_i (.clock(clock), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
   .alertOe(alertOe), .statusFlags(statusFlags), .invalidCommand(invalidCommand), .outputOnCmd(outputOnCmd),
   .voutFormat(voutFormat), .cmdValid(cmdValid), .writeWord(writeWord), .writeExec(writeExec),
   .pecError(pecError), .wordExponent(wordExponent), .wordMantissa(wordMantissa), .busAbort(busAbort));

// ---- sim/pmbus_host_model.sv ----
module pmbus_host_model
(
   input wire clock,
   input wire sdaLine,
   output logic sclLow,
   output logic sdaLow
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {sclLow, sdaLow} = 2'b00;
   // Third of a 120 ns bit, well above the slowest legal rate
   task automatic drive(input logic c, input logic d);
      sclLow = c;
      sdaLow = d;
      repeat (5) @(negedge clock);
   endtask
   // SCL falls first so data is set while the clock is low; only the last step moves it with the clock high
   task automatic cond(input logic stop);
      drive(1'b1, sdaLow);
      drive(1'b1, stop);
      drive(1'b0, stop);
      drive(1'b0, !stop);
   endtask
   // Ninth bit: released to sample the ack on writes, ack or nack on reads
   task automatic byteIo(input logic [7:0] tx, input logic ninth, output logic [7:0] rx, output logic last);
      logic [8:0] v;
      logic [8:0] s;
      v = {tx, ninth};
      for (int i = 8; i >= 0; i--)
      begin
         drive(1'b1, sdaLow);
         drive(1'b1, !v[i]);
         drive(1'b0, !v[i]);
         s = {s[7:0], sdaLine};
      end
      rx = s[8:1];
      last = s[0];
   endtask
   task automatic holdLow(input int n);
      sdaLow = 1'b1;
      repeat (n) @(negedge clock);
      drive(1'b0, 1'b0);
   endtask
endmodule // pmbus_host_model

// ---- sim/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOCK = 2000;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sclLow, sdaLow, sclOe, sdaOe, alertOe, pecPresent, writeExec, pecError, busAbort;
   logic [2:0] pins = 3'h5;
   logic enablePinN = 1'b0;
   logic [5:0] statusFlags = 6'h00;
   logic invalidCommand = 1'b0;
   logic outputOnCmd = 1'b1;
   logic voutFormat = 1'b0;
   logic [5:0] writeLength = 6'h02;
   logic [5:0] readLength = 6'h02;
   logic [5:0] readIndex;
   logic [7:0] txData = 8'h00;
   logic [7:0] cmdCode, rxData;
   logic readReq;
   int reqs = 0, reqBase = 0;
   logic [15:0] writeWord, wordMantissa;
   logic [4:0] wordExponent;
   int err_count = 0, check_count = 0, execs = 0, pecErrs = 0, aborts = 0, cycles = 0;
   wire sclIn = !(sclLow || sclOe);
   wire sdaIn = !(sdaLow || sdaOe);
   always #4 clock = ~clock;
   psu_pmbus_target_interface #(.LOCKUP_CYCLES(23'h0007D0)) psu_pmbus_target_interface_i (
      .clock(clock), .rst_n(rst_n), .sclIn(sclIn), .sclOut(), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(),
      .sdaOe(sdaOe), .addressSelectPins(pins), .alertOut(), .alertOe(alertOe), .enablePinN(enablePinN),
      .statusFlags(statusFlags), .invalidCommand(invalidCommand), .outputOnCmd(outputOnCmd),
      .writeLength(writeLength), .readLength(readLength), .txData(txData), .voutFormat(voutFormat),
      .cmdCode(cmdCode), .cmdValid(), .rxData(rxData), .rxValid(), .writeWord(writeWord), .writeExec(writeExec),
      .pecPresent(pecPresent), .pecError(pecError), .readReq(readReq), .readIndex(readIndex),
      .wordExponent(wordExponent), .wordMantissa(wordMantissa), .busAbort(busAbort));
   pmbus_host_model pmbus_host_model_i (.clock(clock), .sdaLine(sdaIn), .sclLow(sclLow), .sdaLow(sdaLow));
   always @(negedge clock)
      txData <= (readIndex == 6'h00) ? {2'h0, readLength} - 8'h01 : 8'h10 + {2'h0, readIndex};
   always @(posedge clock)
   begin
      cycles++;
      if (writeExec === 1'b1)
         execs++;
      if (pecError === 1'b1)
         pecErrs++;
      if (busAbort === 1'b1)
         aborts++;
      if (readReq === 1'b1)
         reqs++;
      if (cycles == 40000)
      begin
         err_count++;
         final_report;
      end
   end
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic sendB(input logic [7:0] b, inout logic [7:0] crc, output logic ack);
      logic [7:0] rx;
      logic nak;
      pmbus_host_model_i.byteIo(b, 1'b1, rx, nak);
      ack = !nak;
      crc = crc8(crc, b);
   endtask
   task automatic wr(input logic [7:0] a, c, input logic [15:0] w, input int n, input bit pec, bad, expAck);
      logic [7:0] crc;
      logic ack;
      crc = 8'h00;
      pmbus_host_model_i.cond(1'b0);
      sendB(a, crc, ack);
      chk(ack, expAck);
      sendB(c, crc, ack);
      chk(ack, expAck);
      for (int i = 0; i < n; i++)
      begin
         sendB(w[8*i +: 8], crc, ack);
         chk(ack, expAck);
      end
      if (pec)
         sendB(crc ^ {7'h00, bad}, crc, ack);
      pmbus_host_model_i.cond(1'b1);
      repeat (10) @(negedge clock);
   endtask
   task automatic rd(input logic [7:0] c, input int n);
      logic [7:0] crc, b;
      logic ack;
      crc = 8'h00;
      pmbus_host_model_i.cond(1'b0);
      sendB(8'hBA, crc, ack);
      sendB(c, crc, ack);
      pmbus_host_model_i.cond(1'b0);
      sendB(8'hBB, crc, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         pmbus_host_model_i.byteIo(8'hFF, 1'b0, b, ack);
         chk(b, i == 0 ? n - 1 : 8'h10 + i);
         crc = crc8(crc, b);
      end
      pmbus_host_model_i.byteIo(8'hFF, 1'b1, b, ack);
      chk(b, crc);
      pmbus_host_model_i.cond(1'b1);
      // Gap stands in for the long settle time, scaled down
      repeat (10) @(negedge clock);
   endtask
   task automatic t_writes;
      voutFormat = 1'b1;
      wr(8'hBA, 8'h21, 16'h1234, 2, 1, 0, 1);
      chk(execs, 1);
      chk(cmdCode, 16'h0021);
      chk(pecPresent, 1'b1);
      chk(writeWord, 16'h1234);
      voutFormat = 1'b0;
      wr(8'hBA, 8'h22, 16'hF801, 2, 0, 0, 1);
      chk(execs, 2);
      chk(pecPresent, 1'b0);
      chk(wordExponent, 5'h1F);
      chk(rxData, 16'h00F8);
      wr(8'hBA, 8'h21, 16'h0055, 2, 1, 1, 1);
      chk(pecErrs, 1);
      chk(execs, 2);
      chk(alertOe, 1'b1);
      writeLength = 6'h00;
      wr(8'hBA, 8'h03, 16'h0000, 0, 1, 0, 1);
      chk(alertOe, 1'b0);
   endtask
   task automatic t_read;
      @(negedge clock) invalidCommand = 1'b1;
      @(negedge clock) invalidCommand = 1'b0;
      chk(alertOe, 1'b1);
      reqBase = reqs;
      rd(8'h79, 2);
      chk(alertOe, 1'b0);
      chk(reqs - reqBase, 4);
      readLength = 6'h04;
      rd(8'h9A, 4);
   endtask
   task automatic t_alert;
      statusFlags = 6'h01;
      #80 outputOnCmd = 1'b0;
      #80 outputOnCmd = 1'b1;
      #80 chk(alertOe, 1'b1);
      statusFlags = 6'h00;
      #80 outputOnCmd = 1'b0;
      #80 outputOnCmd = 1'b1;
      #80 chk(alertOe, 1'b0);
      invalidCommand = 1'b1;
      #8 invalidCommand = 1'b0;
      #80 enablePinN = 1'b1;
      #80 enablePinN = 1'b0;
      #80 chk(alertOe, 1'b0);
   endtask
   task automatic t_address;
      writeLength = 6'h01;
      wr(8'hAA, 8'h01, 16'h0000, 0, 0, 0, 0);
      wr(8'h00, 8'h01, 16'h0080, 1, 1, 0, 1);
      chk(execs, 4);
      rd(8'h9A, 4);
      wr(8'h01, 8'h01, 16'h0000, 0, 0, 0, 0);
      pins = 3'h2;
      wr(8'hB4, 8'h01, 16'h0080, 1, 0, 0, 1);
      chk(execs, 5);
   endtask
   task automatic t_lockup;
      pmbus_host_model_i.holdLow(LOCK - 500);
      pmbus_host_model_i.holdLow(LOCK - 500);
      chk(aborts, 0);
      pmbus_host_model_i.holdLow(LOCK + 20);
      chk(aborts, 1);
      chk(sdaOe, 1'b0);
      chk(alertOe, 1'b1);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (5) @(negedge clock);
      t_writes;
      t_read;
      t_alert;
      t_address;
      t_lockup;
      final_report;
   end
endmodule // tb_top
